// File: core/instr_exec.sv
// Instruction execution sequencer: length, timing, flags and branches
`timescale 1ns/10ps

module instr_exec
  import exec_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire op_t instr_op,
  input wire mode_t instr_mode,
  input wire logic [BIT_W-1:0] instr_bit,
  input wire logic [LONG_DISP_W-1:0] instr_disp,
  input wire logic [PC_W-1:0] instr_target,
  input wire logic [PC_W-1:0] instr_pc,
  input wire logic [DATA_W-1:0] acc_in,
  input wire logic [DATA_W-1:0] operand_in,
  input wire logic [PC_W-1:0] return_addr,
  input wire logic saved_zero,
  input wire logic saved_carry,
  input wire logic watchdog_opt,
  output logic busy,
  output logic done,
  output logic [LEN_W-1:0] instr_len,
  output logic [CYC_W-1:0] instr_cycles,
  output logic flag_zero,
  output logic flag_carry,
  output logic [PC_W-1:0] next_pc,
  output logic pc_load,
  output logic [DATA_W-1:0] result,
  output logic acc_we,
  output logic data_we,
  output logic push_return,
  output logic branch_taken,
  output logic enter_wait,
  output logic enter_stop
);

  // ==========================================================
  // Latched instruction
  state_t state;
  state_t next_state;
  op_t op;
  mode_t mode;
  logic [BIT_W-1:0] bit_sel;
  logic [LONG_DISP_W-1:0] disp;
  logic [PC_W-1:0] target;
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] operand;
  logic [CYC_W-1:0] count;

  alu_if alu ();

  alu_unit u_alu (
    .bus(alu.unit)
  );

  // Feed the unit from the latched instruction and the carry flag
  assign alu.op = op;
  assign alu.clear_acc = (mode == mode_short_direct);
  assign alu.acc = acc;
  assign alu.operand = operand;
  assign alu.bit_sel = bit_sel;
  assign alu.carry_in = flag_carry;

  // ==========================================================
  // Length and cycle decode of the incoming instruction
  logic [LEN_W-1:0] dec_len;
  logic [CYC_W-1:0] dec_cycles;
  logic is_alu;
  logic alu_two_bytes;

  assign is_alu = (instr_op >= op_sum);
  assign alu_two_bytes = (instr_mode == mode_direct)
                      || (instr_mode == mode_immediate)
                      || (instr_op == op_shift_left_accumulator);

  always_comb begin
    dec_len = LEN_ONE;
    dec_cycles = CYC_SHORT;
    if (is_alu) begin
      dec_cycles = CYC_NORMAL;
      if (instr_op == op_clear && instr_mode == mode_direct) begin
        dec_len = LEN_THREE;
      end else if (instr_op == op_clear || alu_two_bytes) begin
        dec_len = LEN_TWO;
      end
    end else if (instr_op == op_bit_clear_test_branch
              || instr_op == op_bit_high_test_branch) begin
      dec_len = LEN_THREE;
      dec_cycles = CYC_BIT_TEST;
    end else if (instr_op == op_bit_force_high
              || instr_op == op_bit_force_low) begin
      dec_len = LEN_TWO;
      dec_cycles = CYC_NORMAL;
    end else if (instr_op == op_jump || instr_op == op_call) begin
      dec_len = LEN_TWO;
      dec_cycles = CYC_NORMAL;
    end else begin
      dec_len = LEN_ONE;
      dec_cycles = CYC_SHORT;
    end
  end

  // ==========================================================
  // Branch targets and conditions
  logic [PC_W-1:0] short_ext;
  logic [PC_W-1:0] long_ext;
  logic [PC_W-1:0] short_target;
  logic [PC_W-1:0] long_target;
  logic [PC_W-1:0] fall_through;
  logic is_short_br;
  logic is_bit_br;
  logic short_cond;
  logic bit_cond;
  logic take;

  // Sign extension of the two displacement sizes
  assign short_ext = {{(PC_W-SHORT_DISP_W){disp[SHORT_DISP_W-1]}},
                      disp[SHORT_DISP_W-1:0]};
  assign long_ext = {{(PC_W-LONG_DISP_W){disp[LONG_DISP_W-1]}},
                     disp};
  assign short_target = pc + SHORT_BR_BIAS + short_ext;
  assign long_target = pc + BIT_BR_BIAS + long_ext;
  assign fall_through = pc + {{(PC_W-LEN_W){1'b0}}, instr_len};

  assign is_short_br = (op == op_branch_short_on_carry)
                    || (op == op_branch_short_on_no_carry)
                    || (op == op_branch_short_on_zero)
                    || (op == op_branch_short_on_nonzero);
  assign is_bit_br = (op == op_bit_clear_test_branch)
                  || (op == op_bit_high_test_branch);

  // Short branch condition on the current flags
  assign short_cond = (op == op_branch_short_on_carry) ? flag_carry
                    : (op == op_branch_short_on_no_carry) ? !flag_carry
                    : (op == op_branch_short_on_zero) ? flag_zero
                    : !flag_zero;
  // Bit-test polarity
  assign bit_cond = (op == op_bit_high_test_branch) ? alu.bit_value
                  : !alu.bit_value;
  assign take = (is_short_br && short_cond) || (is_bit_br && bit_cond);

  // ==========================================================
  // Completion values
  logic [PC_W-1:0] next_target;
  logic writes_acc;
  logic writes_data;
  logic stop_as_wait;

  assign next_target = (op == op_jump || op == op_call) ? target
                     : (op == op_return
                        || op == op_return_from_interrupt) ? return_addr
                     : (is_short_br && take) ? short_target
                     : (is_bit_br && take) ? long_target
                     : fall_through;
  assign writes_acc = (op == op_sum) || (op == op_mask)
                   || (op == op_difference) || (op == op_complement)
                   || (op == op_rotate_left_through_carry)
                   || (op == op_shift_left_accumulator)
                   || (op == op_clear && mode == mode_short_direct);
  assign writes_data = (op == op_increment) || (op == op_decrement)
                    || (op == op_bit_force_high)
                    || (op == op_bit_force_low)
                    || (op == op_clear && mode != mode_short_direct);
  assign stop_as_wait = (op == op_stop) && watchdog_opt;

  // ==========================================================
  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (instr_valid) begin
          next_state = st_run;
        end
      end
      st_run: begin
        if (count == CYC_ZERO) begin
          next_state = st_done;
        end
      end
      st_done: begin
        next_state = st_idle;
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  // State and cycle counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      count <= CYC_ZERO;
    end else begin
      state <= next_state;
      if (state == st_idle && instr_valid) begin
        count <= dec_cycles - CYC_ONE;
      end else if (state == st_run && count != CYC_ZERO) begin
        count <= count - CYC_ONE;
      end
    end
  end

  // Capture of the instruction on acceptance
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op <= op_nop;
      mode <= mode_inherent;
      bit_sel <= '0;
      disp <= '0;
      target <= PC_RESET;
      pc <= PC_RESET;
      acc <= BYTE_ZERO;
      operand <= BYTE_ZERO;
      instr_len <= LEN_ONE;
      instr_cycles <= CYC_SHORT;
    end else if (state == st_idle && instr_valid) begin
      op <= instr_op;
      mode <= instr_mode;
      bit_sel <= instr_bit;
      disp <= instr_disp;
      target <= instr_target;
      pc <= instr_pc;
      acc <= acc_in;
      operand <= operand_in;
      instr_len <= dec_len;
      instr_cycles <= dec_cycles;
    end
  end

  // Flags: only the unit's update bits or interrupt return change them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_zero <= 1'b0;
      flag_carry <= 1'b0;
    end else if (state == st_run && count == CYC_ZERO) begin
      if (op == op_return_from_interrupt) begin
        flag_zero <= saved_zero;
        flag_carry <= saved_carry;
      end else begin
        if (alu.zero_upd) begin
          flag_zero <= alu.zero;
        end
        if (alu.carry_upd) begin
          flag_carry <= alu.carry;
        end
      end
    end
  end

  // Completion outputs, one cycle long except busy, next_pc and result, which hold
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      pc_load <= 1'b0;
      next_pc <= PC_RESET;
      result <= BYTE_ZERO;
      acc_we <= 1'b0;
      data_we <= 1'b0;
      push_return <= 1'b0;
      branch_taken <= 1'b0;
      enter_wait <= 1'b0;
      enter_stop <= 1'b0;
    end else begin
      busy <= (next_state != st_idle);
      done <= (state == st_run && count == CYC_ZERO);
      pc_load <= (state == st_run && count == CYC_ZERO);
      acc_we <= (state == st_run && count == CYC_ZERO) && writes_acc;
      data_we <= (state == st_run && count == CYC_ZERO) && writes_data;
      push_return <= (state == st_run && count == CYC_ZERO)
                  && (op == op_call);
      branch_taken <= (state == st_run && count == CYC_ZERO) && take;
      enter_wait <= (state == st_run && count == CYC_ZERO)
                 && (op == op_wait || stop_as_wait);
      enter_stop <= (state == st_run && count == CYC_ZERO)
                 && (op == op_stop) && !watchdog_opt;
      if (state == st_run && count == CYC_ZERO) begin
        next_pc <= next_target;
        result <= alu.result;
      end
    end
  end

endmodule

// File: core/exec_pkg.sv
// Shared types and constants for the instruction execution block
package exec_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int BIT_W = 3;
  localparam int SHORT_DISP_W = 5;
  localparam int LONG_DISP_W = 8;
  localparam int LEN_W = 2;
  localparam int CYC_W = 3;

  // ==========================================================
  // Instruction lengths in bytes
  localparam logic [LEN_W-1:0] LEN_ONE = 2'h1;
  localparam logic [LEN_W-1:0] LEN_TWO = 2'h2;
  localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;

  // ==========================================================
  // Cycle counts
  localparam logic [CYC_W-1:0] CYC_SHORT = 3'h2;
  localparam logic [CYC_W-1:0] CYC_NORMAL = 3'h4;
  localparam logic [CYC_W-1:0] CYC_BIT_TEST = 3'h5;
  localparam logic [CYC_W-1:0] CYC_ONE = 3'h1;
  localparam logic [CYC_W-1:0] CYC_ZERO = 3'h0;

  // ==========================================================
  // Branch offsets: target = pc + bias + signed displacement
  localparam logic [PC_W-1:0] SHORT_BR_BIAS = 12'h001;
  localparam logic [PC_W-1:0] BIT_BR_BIAS = 12'h002;
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;

  // ==========================================================
  // Data constants
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;

  // ==========================================================
  // Decoded operations
  typedef enum logic [4:0] {
    op_nop = 5'h00,
    op_return = 5'h01,
    op_return_from_interrupt = 5'h02,
    op_stop = 5'h03,
    op_wait = 5'h04,
    op_branch_short_on_carry = 5'h05,
    op_branch_short_on_no_carry = 5'h06,
    op_branch_short_on_zero = 5'h07,
    op_branch_short_on_nonzero = 5'h08,
    op_bit_clear_test_branch = 5'h09,
    op_bit_high_test_branch = 5'h0A,
    op_bit_force_high = 5'h0B,
    op_bit_force_low = 5'h0C,
    op_jump = 5'h0D,
    op_call = 5'h0E,
    op_sum = 5'h0F,
    op_mask = 5'h10,
    op_compare = 5'h11,
    op_difference = 5'h12,
    op_increment = 5'h13,
    op_decrement = 5'h14,
    op_complement = 5'h15,
    op_rotate_left_through_carry = 5'h16,
    op_shift_left_accumulator = 5'h17,
    op_clear = 5'h18
  } op_t;

  // Addressing form of the operand
  typedef enum logic [2:0] {
    mode_inherent = 3'h0,
    mode_short_direct = 3'h1,
    mode_direct = 3'h2,
    mode_indirect = 3'h3,
    mode_immediate = 3'h4
  } mode_t;

  // Execution sequencer, Gray coded along idle-run-done
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_run = 2'b01,
    st_done = 2'b11
  } state_t;

endpackage

// File: core/alu_if.sv
// Carrier between the sequencer and the arithmetic/bit unit
`timescale 1ns/10ps
interface alu_if;
  import exec_pkg::*;
  op_t op;
  logic clear_acc;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] operand;
  logic [BIT_W-1:0] bit_sel;
  logic carry_in;
  logic [DATA_W-1:0] result;
  logic zero;
  logic carry;
  logic zero_upd;
  logic carry_upd;
  logic bit_value;

  modport req (
    output op, clear_acc, acc, operand, bit_sel, carry_in,
    input result, zero, carry, zero_upd, carry_upd, bit_value
  );
  modport unit (
    input op, clear_acc, acc, operand, bit_sel, carry_in,
    output result, zero, carry, zero_upd, carry_upd, bit_value
  );
endinterface

// File: core/alu_unit.sv
// Arithmetic, logic and bit unit with flag effects
`timescale 1ns/10ps
module alu_unit
  import exec_pkg::*;
(
  alu_if.unit bus
);

  // ==========================================================
  // Operand helpers
  logic [DATA_W:0] wide_sum;
  logic [DATA_W:0] wide_diff;
  logic [DATA_W-1:0] bit_mask;
  logic [DATA_W-1:0] incremented;
  logic [DATA_W-1:0] decremented;

  assign wide_sum = {1'b0, bus.acc} + {1'b0, bus.operand};
  assign wide_diff = {1'b0, bus.acc} - {1'b0, bus.operand};
  assign bit_mask = BYTE_ONE << bus.bit_sel;
  assign incremented = bus.operand + BYTE_ONE;
  assign decremented = bus.operand - BYTE_ONE;
  assign bus.bit_value = |(bus.operand & bit_mask);
  assign bus.zero = (bus.result == BYTE_ZERO);

  // ==========================================================
  // Result and flag selection
  always_comb begin
    bus.result = bus.operand;
    bus.carry = bus.carry_in;
    bus.zero_upd = 1'b0;
    bus.carry_upd = 1'b0;
    case (bus.op)
      op_sum: begin
        bus.result = wide_sum[DATA_W-1:0];
        bus.carry = wide_sum[DATA_W];
        bus.zero_upd = 1'b1;
        bus.carry_upd = 1'b1;
      end
      op_mask: begin
        bus.result = bus.acc & bus.operand;
        bus.carry = 1'b0;
        bus.zero_upd = 1'b1;
        bus.carry_upd = 1'b1;
      end
      op_compare, op_difference: begin
        bus.result = wide_diff[DATA_W-1:0];
        bus.carry = wide_diff[DATA_W];
        bus.zero_upd = 1'b1;
        bus.carry_upd = 1'b1;
      end
      op_increment: begin
        bus.result = incremented;
        bus.zero_upd = 1'b1;
      end
      op_decrement: begin
        bus.result = decremented;
        bus.zero_upd = 1'b1;
      end
      op_complement: begin
        bus.result = ~bus.acc;
        bus.carry = bus.acc[DATA_W-1];
        bus.zero_upd = 1'b1;
        bus.carry_upd = 1'b1;
      end
      op_rotate_left_through_carry: begin
        bus.result = {bus.acc[DATA_W-2:0], bus.carry_in};
        bus.carry = bus.acc[DATA_W-1];
        bus.zero_upd = 1'b1;
        bus.carry_upd = 1'b1;
      end
      op_shift_left_accumulator: begin
        bus.result = {bus.acc[DATA_W-2:0], 1'b0};
        bus.carry = bus.acc[DATA_W-1];
        bus.zero_upd = 1'b1;
        bus.carry_upd = 1'b1;
      end
      op_clear: begin
        bus.result = BYTE_ZERO;
        bus.carry = 1'b0;
        bus.zero_upd = bus.clear_acc;
        bus.carry_upd = bus.clear_acc;
      end
      op_bit_force_high: begin
        bus.result = bus.operand | bit_mask;
      end
      op_bit_force_low: begin
        bus.result = bus.operand & ~bit_mask;
      end
      op_bit_clear_test_branch, op_bit_high_test_branch: begin
        bus.carry = bus.bit_value;
        bus.carry_upd = 1'b1;
      end
      default: begin
        bus.result = bus.operand;
      end
    endcase
  end

endmodule

// File: bench/data_space_model.sv
// Data space memory standing behind the execution block
`timescale 1ns/10ps
module data_space_model
  import exec_pkg::*;
(
  input wire logic mclk,
  input wire logic [DATA_W-1:0] addr,
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [256];

  // Reads are immediate, writes land on the clock edge
  assign rd_data = mem[addr];
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end
endmodule

// File: bench/exec_sva.sv
// Concurrent property checker for the instruction execution sequencer
`timescale 1ns/10ps
module exec_sva
  import exec_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire op_t instr_op,
  input wire logic [BIT_W-1:0] instr_bit,
  input wire logic [LONG_DISP_W-1:0] instr_disp,
  input wire logic [PC_W-1:0] instr_target,
  input wire logic [PC_W-1:0] instr_pc,
  input wire logic [DATA_W-1:0] operand_in,
  input wire logic watchdog_opt,
  input wire logic busy,
  input wire logic done,
  input wire logic [LEN_W-1:0] instr_len,
  input wire logic [CYC_W-1:0] instr_cycles,
  input wire logic flag_zero,
  input wire logic flag_carry,
  input wire logic [PC_W-1:0] next_pc,
  input wire logic [DATA_W-1:0] result,
  input wire logic branch_taken,
  input wire logic enter_wait,
  input wire logic enter_stop
);
  // ==========================================================
  // Request capture
  op_t c_op;
  logic [PC_W-1:0] c_pc;
  logic [LONG_DISP_W-1:0] c_disp;
  logic [DATA_W-1:0] c_opnd;
  logic [BIT_W-1:0] c_bit;
  wire accept = instr_valid && !busy && !done;
  wire tbit = c_opnd[c_bit];
  wire [DATA_W-1:0] bmask = BYTE_ONE << c_bit;
  wire [PC_W-1:0] s_tgt = c_pc + SHORT_BR_BIAS +
    {{7{c_disp[4]}}, c_disp[4:0]};
  wire [PC_W-1:0] b_tgt = c_pc + BIT_BR_BIAS + {{4{c_disp[7]}}, c_disp};
  wire c_short = c_op inside {[op_branch_short_on_carry:
    op_branch_short_on_nonzero]};

  // Hold the fields of the accepted instruction
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c_op <= op_nop;
      c_pc <= PC_RESET;
      c_disp <= BYTE_ZERO;
      c_opnd <= BYTE_ZERO;
      c_bit <= 3'h0;
    end else if (accept) begin
      c_op <= instr_op;
      c_pc <= instr_pc;
      c_disp <= instr_disp;
      c_opnd <= operand_in;
      c_bit <= instr_bit;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  short_form_a: assert property (
    accept && instr_op inside {[op_branch_short_on_carry:
    op_branch_short_on_nonzero]} |=> instr_len == LEN_ONE &&
    instr_cycles == CYC_SHORT ##2 done &&
    flag_zero == $past(flag_zero, 3) && flag_carry == $past(flag_carry, 3))
    else $error("short branch form wrong");
  short_target_a: assert property (
    done && c_short |-> next_pc ==
    (branch_taken ? s_tgt : c_pc + SHORT_BR_BIAS))
    else $error("short branch target wrong");
  bit_test_a: assert property (
    accept && instr_op inside {op_bit_clear_test_branch,
    op_bit_high_test_branch} |=> instr_len == LEN_THREE &&
    instr_cycles == CYC_BIT_TEST ##5 done && flag_carry == tbit &&
    flag_zero == $past(flag_zero, 6))
    else $error("bit test form wrong");
  bit_clear_br_a: assert property (
    done && c_op == op_bit_clear_test_branch |-> branch_taken == !tbit &&
    next_pc == (tbit ? c_pc + 12'h003 : b_tgt))
    else $error("bit clear branch wrong");
  bit_high_br_a: assert property (
    done && c_op == op_bit_high_test_branch |-> branch_taken == tbit &&
    next_pc == (tbit ? b_tgt : c_pc + 12'h003))
    else $error("bit high branch wrong");
  force_value_a: assert property (
    done && c_op inside {op_bit_force_high, op_bit_force_low} |->
    result == (c_op == op_bit_force_high ? c_opnd | bmask : c_opnd & ~bmask))
    else $error("bit force value wrong");
  force_form_a: assert property (
    accept && instr_op inside {op_bit_force_high, op_bit_force_low} |=>
    instr_len == LEN_TWO && instr_cycles == CYC_NORMAL ##4 done &&
    flag_zero == $past(flag_zero, 5) && flag_carry == $past(flag_carry, 5))
    else $error("bit force form wrong");
  control_form_a: assert property (
    accept && instr_op inside {op_nop, op_return, op_stop, op_wait} |=>
    instr_len == LEN_ONE && instr_cycles == CYC_SHORT ##2 done &&
    flag_zero == $past(flag_zero, 3) && flag_carry == $past(flag_carry, 3))
    else $error("control form wrong");
  stop_swap_a: assert property (
    done && c_op == op_stop |-> enter_wait == $past(watchdog_opt) &&
    enter_stop == !$past(watchdog_opt))
    else $error("stop replacement wrong");
  jump_form_a: assert property (
    accept && instr_op inside {op_jump, op_call} |=> instr_len == LEN_TWO &&
    instr_cycles == CYC_NORMAL ##4 done &&
    next_pc == $past(instr_target, 5) && flag_carry == $past(flag_carry, 5))
    else $error("jump form wrong");
  step_carry_a: assert property (
    accept && instr_op inside {op_increment, op_decrement} |->
    ##5 done && flag_carry == $past(flag_carry, 5))
    else $error("step carry changed");

  cover property (accept && instr_op == op_bit_high_test_branch);
  cover property (done && c_short && branch_taken);
  cover property (done && enter_wait && c_op == op_stop);
endmodule

bind instr_exec exec_sva exec_sva_inst (.*);

// File: bench/tb_instr_exec.sv
// Self-checking testbench for the instruction execution sequencer
`timescale 1ns/10ps
module tb_instr_exec;
  import exec_pkg::*;
  logic mclk, rst_n, instr_valid, saved_zero, saved_carry, watchdog_opt;
  logic busy, done, flag_zero, flag_carry, pc_load, acc_we, data_we;
  logic push_return, branch_taken, enter_wait, enter_stop, ld_we;
  op_t instr_op;
  mode_t instr_mode;
  logic [BIT_W-1:0] instr_bit;
  logic [LONG_DISP_W-1:0] instr_disp;
  logic [PC_W-1:0] instr_target, instr_pc, return_addr, next_pc;
  logic [DATA_W-1:0] acc_in, operand_in, result, addr, ld_data;
  logic [LEN_W-1:0] instr_len;
  logic [CYC_W-1:0] instr_cycles;
  int bad_count, comparisons, took;

  instr_exec instr_exec_inst (.*);
  data_space_model data_space_model_inst (.mclk, .addr,
    .wr_en(data_we | ld_we), .wr_data(ld_we ? ld_data : result),
    .rd_data(operand_in));

  // Clock source
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check_flag(input logic got, exp, input string s);
    check_word(PC_W'(got), PC_W'(exp), s);
  endtask
  task automatic check_word(input logic [PC_W-1:0] got, exp,
      input string s);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, s);
    end
  endtask
  task automatic shape(input logic [LEN_W-1:0] l, input logic [CYC_W-1:0] c);
    check_word(PC_W'(instr_len), PC_W'(l), "length");
    check_word(PC_W'(instr_cycles), PC_W'(c), "cycles");
    check_word(PC_W'(took), PC_W'(c), "done delay");
  endtask
  task automatic keep(input logic z, c);
    check_flag(flag_zero, z, "zero");
    check_flag(flag_carry, c, "carry");
  endtask
  task automatic load(input logic [DATA_W-1:0] a, v);
    @(posedge mclk);
    addr <= a;
    ld_data <= v;
    ld_we <= 1'b1;
    @(posedge mclk);
    ld_we <= 1'b0;
  endtask
  // Present one instruction, return in its done cycle
  task automatic run(input op_t op, input mode_t md,
      input logic [BIT_W-1:0] b, input logic [LONG_DISP_W-1:0] d);
    @(posedge mclk);
    instr_op <= op;
    instr_mode <= md;
    instr_bit <= b;
    instr_disp <= d;
    instr_valid <= 1'b1;
    @(posedge mclk);
    instr_valid <= 1'b0;
    took = 0;
    do begin
      @(posedge mclk);
      #1;
      took++;
    end while (done !== 1'b1 && took < 8);
  endtask
  task automatic alu(input op_t op, input mode_t md,
      input logic [DATA_W-1:0] a, v, r, input logic [1:0] zc, l);
    load(8'h40, v);
    acc_in <= a;
    run(op, md, 3'h0, 8'h00);
    check_flag(acc_we ^ data_we, op != op_compare, "dest");
    if (op != op_compare) begin
      check_word(PC_W'(result), PC_W'(r), "result");
    end
    keep(zc[1], zc[0]);
    shape(l, CYC_NORMAL);
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_alu;
    alu(op_sum, mode_direct, 8'hFF, 8'h01, 8'h00, 2'h3, 2'h2);
    alu(op_increment, mode_direct, 8'h00, 8'hFF, 8'h00, 2'h3, 2'h2);
    alu(op_mask, mode_immediate, 8'h0F, 8'hF0, 8'h00, 2'h2, 2'h2);
    alu(op_decrement, mode_indirect, 8'h00, 8'h01, 8'h00, 2'h2, 2'h1);
    alu(op_compare, mode_direct, 8'h20, 8'h20, 8'h00, 2'h2, 2'h2);
    alu(op_difference, mode_direct, 8'h10, 8'h20, 8'hF0, 2'h1, 2'h2);
    alu(op_clear, mode_direct, 8'h10, 8'h20, 8'h00, 2'h1, 2'h3);
    alu(op_rotate_left_through_carry, mode_inherent, 8'h80, 8'h00,
      8'h01, 2'h1, 2'h1);
    alu(op_shift_left_accumulator, mode_inherent, 8'h80, 8'h00,
      8'h00, 2'h3, 2'h2);
    alu(op_clear, mode_short_direct, 8'h55, 8'h00, 8'h00, 2'h2, 2'h2);
    alu(op_complement, mode_inherent, 8'hFF, 8'h00, 8'h00, 2'h3, 2'h1);
  endtask
  task automatic test_control;
    op_t ctl[4] = '{op_nop, op_return, op_stop, op_wait};
    alu(op_compare, mode_direct, 8'h10, 8'h20, 8'h00, 2'h1, 2'h2);
    foreach (ctl[i]) begin
      run(ctl[i], mode_inherent, 3'h0, 8'h00);
      shape(LEN_ONE, CYC_SHORT);
      keep(1'b0, 1'b1);
      check_flag(enter_stop, ctl[i] == op_stop, "stop");
    end
    @(posedge mclk);
    watchdog_opt <= 1'b1;
    run(op_stop, mode_inherent, 3'h0, 8'h00);
    check_flag(enter_stop, 1'b0, "stop");
    check_flag(enter_wait, 1'b1, "wait");
    run(op_return_from_interrupt, mode_inherent, 3'h0, 8'h00);
    shape(LEN_ONE, CYC_SHORT);
    keep(1'b1, 1'b0);
  endtask
  task automatic test_short;
    op_t sop[4] = '{op_branch_short_on_carry, op_branch_short_on_no_carry,
      op_branch_short_on_zero, op_branch_short_on_nonzero};
    logic [7:0] dsp[4] = '{8'hF0, 8'hF0, 8'hEF, 8'hEF};
    logic [PC_W-1:0] tgt[4] = '{12'h801, 12'h7F1, 12'h810, 12'h801};
    foreach (sop[i]) begin
      run(sop[i], mode_inherent, 3'h0, dsp[i]);
      shape(LEN_ONE, CYC_SHORT);
      keep(1'b1, 1'b0);
      check_word(next_pc, tgt[i], "short target");
    end
  endtask
  task automatic test_bit_branch;
    op_t bop[4] = '{op_bit_high_test_branch, op_bit_clear_test_branch,
      op_bit_clear_test_branch, op_bit_high_test_branch};
    logic [2:0] bb[4] = '{3'h7, 3'h1, 3'h0, 3'h6};
    logic [7:0] bd[4] = '{8'h7F, 8'h80, 8'h80, 8'h7F};
    logic [PC_W-1:0] tgt[4] = '{12'h881, 12'h782, 12'h803, 12'h803};
    logic [0:3] bc = 4'b1010;
    logic [0:3] bt = 4'b1100;
    load(8'h40, 8'h81);
    foreach (bop[i]) begin
      run(bop[i], mode_direct, bb[i], bd[i]);
      shape(LEN_THREE, CYC_BIT_TEST);
      keep(1'b1, bc[i]);
      check_flag(branch_taken, bt[i], "taken");
      check_word(next_pc, tgt[i], "bit target");
    end
  endtask
  task automatic test_force;
    logic [7:0] e;
    for (int b = 0; b < 8; b++) begin
      for (int h = 0; h < 2; h++) begin
        e = 8'h01 << b;
        load({3'(b), 5'h1F}, h ? 8'h00 : 8'hFF);
        run(h ? op_bit_force_high : op_bit_force_low, mode_direct, 3'(b),
          8'h00);
        shape(LEN_TWO, CYC_NORMAL);
        keep(1'b1, 1'b0);
        check_flag(data_we, 1'b1, "write");
        @(posedge mclk);
        #1;
        e = h ? e : ~e;
        check_word(PC_W'(operand_in), PC_W'(e), "byte");
      end
    end
  endtask
  task automatic test_jump;
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      instr_target <= k ? 12'h000 : 12'hFFF;
      run(k ? op_call : op_jump, mode_direct, 3'h0, 8'h00);
      shape(LEN_TWO, CYC_NORMAL);
      keep(1'b1, 1'b0);
      check_word(next_pc, k ? 12'h000 : 12'hFFF, "jump");
      check_flag(pc_load, 1'b1, "load");
      check_flag(push_return, k[0], "push");
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_n, instr_valid, saved_carry, watchdog_opt, ld_we} = 5'h0;
    {instr_bit, instr_disp, instr_target, acc_in, ld_data} = 39'h0;
    instr_op = op_nop;
    instr_mode = mode_inherent;
    instr_pc = 12'h800;
    return_addr = 12'h123;
    saved_zero = 1'b1;
    addr = 8'h40;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    test_alu();
    $display("alu test end");
    test_control();
    $display("control test end");
    test_short();
    $display("short branch test end");
    test_bit_branch();
    $display("bit branch test end");
    test_force();
    $display("bit force test end");
    test_jump();
    $display("jump test end");
    summarize();
  end

  // Hang guard
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    summarize();
  end
endmodule
